// ==== rtl/cache_ctrl_defines.vh ====
// constants for the cache replacement and array access block
`ifndef CACHE_CTRL_DEFINES_VH
`define CACHE_CTRL_DEFINES_VH
`define CTRL_REG_OFF 12'h000
`define ACCESS_REG_OFF 12'h004
`define DATA_REG_OFF 12'h008
`define RESULT_REG_OFF 12'h00C
`define STATUS_REG_OFF 12'h010
`define CTRL_ENABLE_BIT 0
`define CTRL_PURGE_BIT 4
`define CTRL_DFILL_OFF_BIT 3
`define CTRL_IFILL_OFF_BIT 1
`define CTRL_HALF_RAM_BIT 5
`define CTRL_WAY_LO_BIT 6
`define CTRL_WAY_HI_BIT 7
`define CMD_CACHE_READ 3'h0
`define CMD_CACHE_WRITE 3'h1
`define CMD_IFETCH 3'h2
`define REGION_PURGE 3'h2
`define REGION_ADDR_ARRAY 3'h3
`define REGION_DATA_ARRAY 3'h6
`define LRU_RESET 6'h00
`define PURGE_CYCLES 2
`define DATA_WRITE_CYCLES 2
`endif

// ==== rtl/cache_ctrl.v ====
// cache replacement, purge and array access control with an apb register port
// Overview of operation
// - six pairwise recency bits per entry
// - update history on hits and refills
// - fixed set/clear pattern per touched way
// - victim is way all arrows point to
// - purge zeroes history, fill order 3,2,1,0
// - fill-off bits stop allocation on read and fetch misses; write misses still allocate
// - half-ram mode victims only ways 2,3
// - tags compared in all ways; software clears 0,1
// - tag/valid written early; aborted refill needs purge
// - purge-all clears valid and history in one cycle
// - reset clears cache enable
// - offset alias purges matching line in all ways
// - line purge takes two cycles, longword access
// - purged dirty line is not written back
// - data array: any size, read 1, write 2 cycles
// - data array one kilobyte per way consecutively
// - data array as ram in half or disabled
// - address array window, way from select bits
// - address array returns tag, history, valid
`timescale 1ns/10ps
`include "cache_ctrl_defines.vh"
module cache_ctrl #(
   parameter ENTRIES = 64,
   parameter WAYS = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg cache_enable,
   output reg half_ram_mode
);
   // registers of the control block
   reg [7:0] cache_control_reg;
   reg [31:0] access_addr_reg;
   reg [2:0] access_cmd_reg;
   reg [1:0] access_size_reg;
   reg [31:0] access_data_reg;
   reg [31:0] result_reg;
   reg hit_reg, alloc_reg, busy_reg;
   reg [1:0] way_reg;
   reg [1:0] wait_reg;
   // register map on the apb side, byte offsets:
   //   000 control: bit0 enable, bit1 instr fill off, bit3 data fill off,
   //       bit4 purge all (self clearing), bit5 half ram, bits 7:6 way select
   //   004 access address: a write starts one array or cache operation
   //   008 write data for the next operation
   //   00C result of the last lookup or array read
   //   010 status on read: way, alloc, hit, ram usable, busy
   //       on write: command in bits 2:0 and size in bits 5:4
   // region from address bits 31:29:
   //   010 associative purge of one line
   //   011 address array window, way from the select bits
   //   110 data array, one kilobyte per way
   //   anything else is an ordinary cache lookup
   // operation latency after the start write:
   //   purge two cycles, data array write two, all others one
   // software polls busy before it starts the next operation;
   // a start write while busy is dropped, so a poll is never optional
   // purge all wins over a pending operation, which then is lost
   // the memory side of a refill is not modelled here: tag and valid
   // go in at once, so an aborted line read leaves a stale line that
   // only a purge removes
   // dirty flags are kept only so that purges visibly discard them
   // history bits, one per pair of ways, set when the later way was used last:
   //   bit5 ways 0/1, bit4 ways 0/2, bit3 ways 0/3
   //   bit2 ways 1/2, bit1 ways 1/3, bit0 ways 2/3
   // a zeroed history picks way 3 first, then 2, 1 and 0
   // in half ram mode only bit0 matters and ways 2 and 3 alternate
   // an address array write with a nonzero history can break this order
   // instruction and data misses are told apart by the command code
   // the enable bit only gates allocation; lookups still hit when off
   // arrays: tag, valid, dirty, history per entry; data 4 words per line
   reg [18:0] tag_mem [0:ENTRIES*WAYS-1];
   reg valid_mem [0:ENTRIES*WAYS-1];
   reg dirty_mem [0:ENTRIES*WAYS-1];
   reg [5:0] lru_mem [0:ENTRIES-1];
   reg [31:0] data_mem [0:ENTRIES*WAYS*4-1];
   integer i;

   wire purge_all_bit = cache_control_reg[`CTRL_PURGE_BIT];
   wire data_fill_off_bit = cache_control_reg[`CTRL_DFILL_OFF_BIT];
   wire instr_fill_off_bit = cache_control_reg[`CTRL_IFILL_OFF_BIT];
   wire half_ram_mode_bit = cache_control_reg[`CTRL_HALF_RAM_BIT];
   wire way_select_lo = cache_control_reg[`CTRL_WAY_LO_BIT];
   wire way_select_hi = cache_control_reg[`CTRL_WAY_HI_BIT];

   // address split of the pending access
   wire [2:0] region = access_addr_reg[31:29];
   wire [5:0] entry = access_addr_reg[9:4];
   wire [18:0] tag = access_addr_reg[28:10];
   wire [1:0] word_sel = access_addr_reg[3:2];
   wire [5:0] lru_cur = lru_mem[entry];

   // two hits in one entry mean software broke the tag rules; highest way wins
   // parallel tag compare over every way, in every mode
   reg [3:0] match;
   reg [1:0] match_way;
   integer w;
   always @* begin
      match = 4'h0;
      match_way = 2'h0;
      for (w = 0; w < 4; w = w + 1) begin
         if (valid_mem[{entry, w[1:0]}] && tag_mem[{entry, w[1:0]}] == tag) begin
            match[w] = 1'b1;
            match_way = w[1:0];
         end
      end
   end

   // victim choice from the pairwise bits
   reg [1:0] victim;
   always @* begin
      if (half_ram_mode_bit) begin
         victim = lru_cur[0] ? 2'h2 : 2'h3;
      end else if (lru_cur[5] & lru_cur[4] & lru_cur[3]) begin
         victim = 2'h0;
      end else if (~lru_cur[5] & lru_cur[2] & lru_cur[1]) begin
         victim = 2'h1;
      end else if (~lru_cur[4] & ~lru_cur[2] & lru_cur[0]) begin
         victim = 2'h2;
      end else begin
         victim = 2'h3;
      end
   end

   // most recently used update for a touched way
   function [5:0] lru_touch;
      input [5:0] old;
      input [1:0] way;
      begin
         lru_touch = old;
         case (way)
            2'h0: lru_touch = {3'h0, old[2:0]};
            2'h1: lru_touch = {1'b1, old[4:3], 2'h0, old[0]};
            2'h2: lru_touch = {old[5], 1'b1, old[3], 1'b1, old[1], 1'b0};
            2'h3: lru_touch = {old[5:4], 1'b1, old[2], 2'h3};
            default: lru_touch = old;
         endcase
      end
   endfunction

   // data array index: way from bits 11:10, entry, word
   wire [9:0] darray_idx = {access_addr_reg[11:10], access_addr_reg[9:4], word_sel};
   // data array usable as ram when disabled, or ways 0,1 in half mode
   wire darray_ram_ok = ~cache_control_reg[`CTRL_ENABLE_BIT] |
      (half_ram_mode_bit & ~access_addr_reg[11]);
   wire [1:0] aa_way = {way_select_hi, way_select_lo};
   wire [31:0] dword = data_mem[darray_idx];

   // byte-lane merge for sized data array writes
   reg [31:0] merged;
   always @* begin
      merged = dword;
      case (access_size_reg)
         2'h0: case (access_addr_reg[1:0])
            2'h0: merged[31:24] = access_data_reg[7:0];
            2'h1: merged[23:16] = access_data_reg[7:0];
            2'h2: merged[15:8] = access_data_reg[7:0];
            default: merged[7:0] = access_data_reg[7:0];
         endcase
         2'h1: if (access_addr_reg[1]) begin
            merged[15:0] = access_data_reg[15:0];
         end else begin
            merged[31:16] = access_data_reg[15:0];
         end
         default: merged = access_data_reg;
      endcase
   end

   // apb decode; accesses take one cycle of setup plus the access phase
   // a start write only latches the address; the command comes from
   // the last status write, so one command serves a run of starts
   wire apb_wr = psel & penable & pwrite & ~pready;
   wire apb_rd = psel & penable & ~pwrite & ~pready;
   wire go = apb_wr && paddr == `ACCESS_REG_OFF && !busy_reg;

   // control register and enable: reset clears enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cache_control_reg <= 8'h00;
         access_addr_reg <= 32'h0000_0000;
         access_data_reg <= 32'h0000_0000;
         access_cmd_reg <= 3'h0;
         access_size_reg <= 2'h2;
      end else begin
         cache_control_reg[`CTRL_PURGE_BIT] <= 1'b0; // purge bit self clears
         if (apb_wr && paddr == `CTRL_REG_OFF) begin
            cache_control_reg <= pwdata[7:0];
         end
         if (apb_wr && paddr == `DATA_REG_OFF) begin
            access_data_reg <= pwdata;
         end
         if (go) begin
            access_addr_reg <= pwdata;
         end
         if (apb_wr && paddr == `STATUS_REG_OFF) begin
            access_cmd_reg <= pwdata[2:0];
            access_size_reg <= pwdata[5:4];
         end
      end
   end

   // access engine: array updates, history, purges
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         wait_reg <= 2'h0;
         result_reg <= 32'h0000_0000;
         hit_reg <= 1'b0;
         alloc_reg <= 1'b0;
         way_reg <= 2'h0;
      end else begin
         if (purge_all_bit) begin
            // one cycle full purge of valid and history
            for (i = 0; i < ENTRIES*WAYS; i = i + 1) begin
               valid_mem[i] <= 1'b0;
            end
            for (i = 0; i < ENTRIES; i = i + 1) begin
               lru_mem[i] <= `LRU_RESET;
            end
            busy_reg <= 1'b0;
         end else if (go) begin
            busy_reg <= 1'b1;
            wait_reg <= 2'h0;
         end else if (busy_reg) begin
            wait_reg <= wait_reg + 2'h1;
            case (region)
               `REGION_PURGE: begin
                  // second cycle drops matching line, dirty or not
                  if (wait_reg == `PURGE_CYCLES - 1) begin
                     for (i = 0; i < 4; i = i + 1) begin
                        if (match[i]) begin
                           valid_mem[{entry, i[1:0]}] <= 1'b0;
                           dirty_mem[{entry, i[1:0]}] <= 1'b0;
                        end
                     end
                     hit_reg <= |match;
                     busy_reg <= 1'b0;
                  end
               end
               `REGION_ADDR_ARRAY: begin
                  if (access_cmd_reg == `CMD_CACHE_WRITE) begin
                     // tag, valid from address; history from data
                     tag_mem[{entry, aa_way}] <= tag;
                     valid_mem[{entry, aa_way}] <= access_addr_reg[2];
                     lru_mem[entry] <= access_data_reg[9:4];
                  end else begin
                     result_reg <= {3'h0, tag_mem[{entry, aa_way}], lru_cur, 1'b0,
                        valid_mem[{entry, aa_way}], 2'h0};
                  end
                  busy_reg <= 1'b0;
               end
               `REGION_DATA_ARRAY: begin
                  // reads one cycle, writes two
                  if (access_cmd_reg != `CMD_CACHE_WRITE) begin
                     result_reg <= dword;
                     busy_reg <= 1'b0;
                  end else if (wait_reg == `DATA_WRITE_CYCLES - 1) begin
                     // ram_ok is reported only; writing a live cache way is the user's risk
                     data_mem[darray_idx] <= merged;
                     busy_reg <= 1'b0;
                  end
               end
               default: begin
                  // cache area lookup: hit updates history
                  if (|match) begin
                     lru_mem[entry] <= lru_touch(lru_cur, match_way);
                     hit_reg <= 1'b1;
                     alloc_reg <= 1'b0;
                     way_reg <= match_way;
                     result_reg <= data_mem[{match_way, entry, word_sel}];
                     if (access_cmd_reg == `CMD_CACHE_WRITE) begin
                        data_mem[{match_way, entry, word_sel}] <= access_data_reg;
                        dirty_mem[{entry, match_way}] <= 1'b1;
                     end
                  end else if (!cache_control_reg[`CTRL_ENABLE_BIT] ||
                     (access_cmd_reg == `CMD_CACHE_READ && data_fill_off_bit) ||
                     (access_cmd_reg == `CMD_IFETCH && instr_fill_off_bit)) begin
                     // no allocation: data goes straight to the cpu
                     hit_reg <= 1'b0;
                     alloc_reg <= 1'b0;
                  end else begin
                     // refill: tag and valid written at once, not after the line read
                     tag_mem[{entry, victim}] <= tag;
                     valid_mem[{entry, victim}] <= 1'b1;
                     dirty_mem[{entry, victim}] <= access_cmd_reg == `CMD_CACHE_WRITE;
                     lru_mem[entry] <= lru_touch(lru_cur, victim);
                     hit_reg <= 1'b0;
                     alloc_reg <= 1'b1;
                     way_reg <= victim;
                  end
                  busy_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // apb slave: one wait state, zero for unmapped reads, error flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         cache_enable <= 1'b0;
         half_ram_mode <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         cache_enable <= cache_control_reg[`CTRL_ENABLE_BIT];
         half_ram_mode <= half_ram_mode_bit;
         if (apb_rd) begin
            case (paddr)
               `CTRL_REG_OFF: prdata <= {24'h0, cache_control_reg};
               `ACCESS_REG_OFF: prdata <= access_addr_reg;
               `DATA_REG_OFF: prdata <= access_data_reg;
               `RESULT_REG_OFF: prdata <= result_reg;
               `STATUS_REG_OFF: prdata <= {26'h0, way_reg, alloc_reg, hit_reg,
                  darray_ram_ok, busy_reg};
               default: begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end else if (apb_wr && paddr > `STATUS_REG_OFF) begin
            pslverr <= 1'b1;
         end
      end
   end
endmodule // cache_ctrl

// ==== sim/cache_ctrl_asserts.sv ====
// port checks for the cache control block
`timescale 1ns/10ps
`include "cache_ctrl_defines.vh"
module cache_ctrl_asserts #(parameter ENTRIES = 64, parameter WAYS = 4) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire cache_enable,
   input wire half_ram_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a control write completing this cycle
   wire ctrl_wr = psel && penable && pready && pwrite && paddr == `CTRL_REG_OFF;
   a_enable_reset: assert property ($rose(presetn) |-> !cache_enable && !half_ram_mode)
      else $error("mode set after reset");
   a_enable_write: assert property (ctrl_wr |=> cache_enable == $past(pwdata[0]))
      else $error("enable missed write");
   a_half_write: assert property (ctrl_wr |=> half_ram_mode == $past(pwdata[5]))
      else $error("half ram missed write");
   a_enable_cause: assert property ($changed(cache_enable) |-> $past(psel && pwrite))
      else $error("enable moved alone");
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   a_ready_bound: assert property (psel && !penable |=> ##[0:2] pready && psel)
      else $error("no answer");
   a_error_place: assert property (pready && paddr > `STATUS_REG_OFF |-> pslverr)
      else $error("unmapped accepted");
   a_rdata_cause: assert property ($changed(prdata) |-> $past(psel && !pwrite))
      else $error("read data moved");
endmodule // cache_ctrl_asserts
bind cache_ctrl cache_ctrl_asserts #(.ENTRIES(ENTRIES), .WAYS(WAYS)) u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cache_enable,
   .half_ram_mode);

// ==== sim/sw_master.sv ====
// software side model issuing cache operations over apb
`timescale 1ns/10ps
`include "cache_ctrl_defines.vh"
module sw_master (
   input wire pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   output logic timed_out
);
   // idle bus at time zero
   initial begin
      {psel, penable, pwrite, timed_out} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // one transfer, held until pready is sampled; released lines show inverted values
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      if (n >= 50) timed_out = 1'b1;
   endtask
   // command (always longword), address starts it, poll busy, fetch result
   task op(input logic [2:0] c, input logic [31:0] a, output logic [31:0] s,
      output logic [31:0] r);
      logic e;
      int n;
      xfer(1'b1, `STATUS_REG_OFF, {26'h0, 2'h2, 1'b0, c}, r, e);
      xfer(1'b1, `ACCESS_REG_OFF, a, r, e);
      s = 32'h1;
      for (n = 0; n < 20 && s[0] !== 1'b0; n++) xfer(1'b0, `STATUS_REG_OFF, 32'h0, s, e);
      if (s[0] !== 1'b0) timed_out = 1'b1;
      xfer(1'b0, `RESULT_REG_OFF, 32'h0, r, e);
   endtask
   // disable before purging so stale fetches cannot race it
   task reset_cache(input logic [31:0] c);
      logic [31:0] q;
      logic e;
      xfer(1'b1, `CTRL_REG_OFF, 32'h0, q, e);
      xfer(1'b1, `CTRL_REG_OFF, (c & ~32'h1) | 32'h10, q, e);
      xfer(1'b1, `CTRL_REG_OFF, c, q, e);
   endtask
endmodule // sw_master

// ==== sim/tb_cache_ctrl.sv ====
// self-checking testbench for the cache control block
`timescale 1ns/10ps
`include "cache_ctrl_defines.vh"
module tb_cache_ctrl;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic cache_enable, half_ram_mode, timed_out, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, s, r;
   int fails = 0;
   int compares = 0;
   int i;
   cache_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cache_enable, .half_ram_mode);
   sw_master sw (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .timed_out);
   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // region, tag, entry; low nibble 4 is also the valid bit of an array image
   function automatic logic [31:0] ca(input logic [2:0] rg, input int t, input logic [5:0] en);
      return {rg, t[18:0], en, 4'h4};
   endfunction
   // a hung bus ends the run
   always @(posedge pclk) if (timed_out === 1'b1) begin
      fails++;
      print_verdict();
   end
   // status mask 3C is way, alloc, hit
   initial begin
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check({30'h0, half_ram_mode, cache_enable}, 32'h0);
      sw.xfer(1'b0, 12'h020, 32'h0, s, e);
      check({31'h0, e}, 32'h1);
      sw.reset_cache(32'h1);
      for (i = 0; i < 4; i++) begin
         sw.op(`CMD_CACHE_READ, ca(3'h0, i + 1, 6'h05), s, r);
         check(s & 32'h3C, 32'h38 - i * 32'h10);
      end
      sw.op(`CMD_CACHE_READ, ca(3'h0, 1, 6'h05), s, r);
      check(s & 32'h3C, 32'h34);
      sw.op(`CMD_CACHE_WRITE, ca(3'h0, 1, 6'h05), s, r);
      check(s & 32'h3C, 32'h34);
      sw.op(`CMD_CACHE_READ, ca(3'h0, 5, 6'h05), s, r);
      check(s & 32'h3C, 32'h28);
      // view way 2 through the address array, purge the line, miss again
      sw.xfer(1'b1, `CTRL_REG_OFF, 32'h81, s, e);
      sw.op(`CMD_CACHE_READ, ca(3'h3, 0, 6'h05), s, r);
      check(r, ca(3'h0, 5, 6'h1E));
      sw.op(`CMD_CACHE_WRITE, ca(3'h2, 5, 6'h05), s, r);
      sw.op(`CMD_CACHE_READ, ca(3'h3, 0, 6'h05), s, r);
      check(r, ca(3'h0, 5, 6'h1E) & ~32'h4);
      sw.op(`CMD_CACHE_READ, ca(3'h0, 5, 6'h05), s, r);
      check(s & 32'h3C, 32'h18);
      // fill-off bits block allocation; an ordinary data miss still allocates
      for (i = 0; i < 3; i++) begin
         sw.xfer(1'b1, `CTRL_REG_OFF, i == 0 ? 32'h9 : 32'h3, s, e);
         sw.op(i == 1 ? `CMD_IFETCH : `CMD_CACHE_READ, ca(3'h0, 9 + i, 6'h05), s, r);
         check(s & 32'hC, i == 2 ? 32'h8 : 32'h0);
      end
      sw.reset_cache(32'h21);
      check({31'h0, half_ram_mode}, 32'h1);
      for (i = 0; i < 3; i++) begin
         sw.op(`CMD_CACHE_READ, ca(3'h0, 20 + i, 6'h07), s, r);
         check(s & 32'h3C, i == 1 ? 32'h28 : 32'h38);
      end
      sw.reset_cache(32'hE1);
      sw.op(`CMD_CACHE_READ, ca(3'h3, 0, 6'h07), s, r);
      check(r & 32'h3F4, 32'h0);
      // cache off: all four ways act as ram, written first so aliasing shows
      sw.xfer(1'b1, `CTRL_REG_OFF, 32'h0, s, e);
      for (i = 0; i < 8; i++) begin
         if (i < 4) sw.xfer(1'b1, `DATA_REG_OFF, 32'hA5A5_0000 + i, s, e);
         sw.op(i < 4, 32'hC000_0004 + (i % 4) * 32'h400, s, r);
         if (i >= 4) check(r, 32'hA5A5_0000 + i - 4);
      end
      print_verdict();
   end
endmodule // tb_cache_ctrl
